// ===== fsd_map.svh
`ifndef FSD_MAP_SVH
`define FSD_MAP_SVH
// Process controls bit positions
`define FSD_PC_TRACE_EN_BIT 0
`define FSD_PC_RESUME_BIT 9
`define FSD_PC_TFP_BIT 10
`define FSD_PC_SUPV_BIT 1
// Arithmetic controls: imprecise sync flag and condition code
`define FSD_AC_SYNC_BIT 15
`define FSD_AC_CC_LSB 0
// Fault-table entry types
`define FSD_ENTRY_LOCAL 2'h0
`define FSD_ENTRY_SYSTEM 2'h2
// Frame-return status for a fault frame
`define FSD_FRAME_STATUS 3'h1
// Fault record word count and resumption record size in bytes
`define FSD_REC_WORDS 8
`define FSD_RESUME_BYTES 48
`define FSD_RESUME_WORDS 12
// Procedure-table trace-control flag: byte 12, bit 1
`define FSD_PT_TRACE_BYTE 12
`define FSD_PT_TRACE_BIT 1
// Constraint-range fault type and subtype, and trace fault type
`define FSD_TYPE_CONSTRAINT 8'h05
`define FSD_SUB_RANGE 8'h01
`define FSD_TYPE_TRACE 8'h01
// Frame size in bytes opened for the handler
`define FSD_FRAME_BYTES 32'h00000040
// Offsets: resumption words and handler frame from the record base, saved return pointer from the old frame pointer
`define FSD_RES_OFFSET 32'h00000020
`define FSD_RIP_OFFSET 32'h00000008
`define FSD_FRAME_OFFSET 32'h00000060
`endif

// ===== fsd_pkg.sv
package fsd_pkg;
  typedef enum logic [1:0] {FSD_STK_LOCAL, FSD_STK_SUPV, FSD_STK_INTR} fsd_stack_e;
  typedef struct packed {
    logic [7:0] ftype;
    logic [7:0] subtype;
    logic [7:0] flags;
    logic [31:0] fault_ip;
    logic [31:0] data0;
    logic [31:0] data1;
    logic [31:0] data2;
    logic suspended;
  } fsd_fault_s;
  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fsd_mem_req_s;
endpackage

// ===== fsd_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsd_map.svh"
// ----------------------------------------------------------------
// Notes on behaviour
// [RL1] Software keeps the imprecise sync flag set
// [RL2] Trace faults need trace enable and mode
// [RL3] Fault-if tests condition code, raises range fault
// [RL4] Type and subtype written as bytes
// [RL5] Flags byte may stay undefined
// [RL6] Record holds faulting instruction pointer
// [RL7] Record captures process and arithmetic controls
// [RL8] Three fault data words in record
// [RL9] Return pointer saved in local register two
// [RL10] Suspended instruction gets 48-byte resumption record
// [RL11] Records go on the stack in use
// [RL12] Entry type 00: push record, extended call
// [RL13] Suspension pushes resumption record, sets resume
// [RL14] New handler frame with return status 001
// [RL15] Local return: free frame, reload arith, continue
// [RL16] Entry type 10 local: address from table
// [RL17] Supervisor from user: local stack, switch stacks
// [RL18] Supervisor from supervisor: current stack, new frame
// [RL19] Copy table trace flag into trace enable
// [RL20] Supervisor return reloads process controls
// [RL21] Resume flag set: read back resumption record
// [RL22] Restore drops handler changes incl. pending trace
// ----------------------------------------------------------------
module fsd_unit (
  input wire logic clk_in, // Processor clock
  input wire logic sys_rst_in, // Async reset, high
  input wire logic fault_in, // Implicit fault pulse
  input wire fsd_pkg::fsd_fault_s fault_info_in, // Fault details
  input wire logic trace_event_in, // Trace condition seen
  input wire logic [7:0] trace_mode_in, // Trace-mode flags
  input wire logic [7:0] trace_sub_in, // Trace subtype bits
  input wire logic fault_if_in, // Fault-if instruction executes
  input wire logic [2:0] fault_if_cond_in, // Condition mask of the instruction
  input wire logic [31:0] cur_ip_in, // Current instruction pointer
  input wire logic [31:0] next_ip_in, // Next instruction pointer
  input wire logic [31:0] proc_ctl_in, // Process controls
  input wire logic [31:0] arith_ctl_in, // Arithmetic controls
  input wire fsd_pkg::fsd_stack_e stack_in, // Stack in use
  input wire logic [31:0] sp_in, // Current stack pointer
  input wire logic [31:0] fp_in, // Current frame pointer
  input wire logic [31:0] entry_word_in, // Fault-table entry word 0
  input wire logic [31:0] pt_handler_in, // Handler address from table
  input wire logic pt_supv_in, // Table entry is supervisor
  input wire logic [31:0] pt_sp_in, // Supervisor stack pointer
  input wire logic [31:0] pt_ctl_word_in, // Table word holding byte 12
  input wire logic [31:0] resume_word_in, // Resumption word to push
  input wire logic handler_ret_in, // Handler executes ret
  input wire logic [31:0] mem_rdata_in, // Memory read data
  input wire logic mem_ack_in, // Memory access done
  output fsd_pkg::fsd_mem_req_s mem_req_out, // Memory request
  output logic mem_valid_out, // Memory request valid
  output logic [31:0] resume_data_out, // Resumption word to core
  output logic resume_valid_out, // Resumption word valid
  output logic [31:0] handler_ip_out, // Handler to start
  output logic [31:0] new_fp_out, // Handler frame pointer
  output logic [31:0] new_sp_out, // Stack pointer after dispatch
  output logic [2:0] frame_status_out, // Frame-return status
  output logic [31:0] proc_ctl_out, // Process controls to load
  output logic [31:0] arith_ctl_out, // Arithmetic controls to load
  output logic [31:0] return_ip_out, // Where execution continues
  output logic ctl_load_out, // Load controls pulse
  output logic dispatch_out, // Handler start pulse
  output logic resume_out, // Continue program pulse
  output logic busy_out // Unit active
);
  import fsd_pkg::*;

  typedef enum logic [2:0] {
    FSD_IDLE, FSD_WREC, FSD_WRES, FSD_WRIP, FSD_CALL, FSD_RUN,
    FSD_RREC, FSD_RRES
  } fsd_state_e;

  fsd_state_e state;
  fsd_fault_s rec;
  logic [31:0] saved_pc;
  logic [31:0] saved_ac;
  logic [31:0] base;
  logic [31:0] ret_ip;
  logic [31:0] old_fp;
  logic [3:0] idx;
  logic supv_call;
  logic from_user;
  logic [1:0] etype;
  logic [31:0] next_addr;
  logic [31:0] next_wdata;
  logic trig;
  fsd_fault_s trig_info;
  logic cond_met;
  logic [31:0] frame_base;

  // Word address within a record at the base
  function automatic logic [31:0] word_addr(input logic [31:0] b,
                                            input logic [3:0] i);
    word_addr = b + {26'h0, i, 2'h0};
  endfunction

  // Resumption words sit right above the fault record
  function automatic logic [31:0] res_addr(input logic [31:0] b,
                                           input logic [3:0] i);
    res_addr = word_addr(b + `FSD_RES_OFFSET, i);
  endfunction

  // True on the last word of a run of n words
  function automatic logic last_word(input logic [3:0] i,
                                     input logic [3:0] n);
    last_word = (i == n - 4'h1);
  endfunction

  // States that hold a memory request open until it is acknowledged
  function automatic logic mem_state(input fsd_state_e s);
    mem_state = (s == FSD_WREC) || (s == FSD_WRES) || (s == FSD_WRIP) ||
                (s == FSD_RREC) || (s == FSD_RRES);
  endfunction

  // Read states: only the supervisor return reads memory back
  function automatic logic read_state(input fsd_state_e s);
    read_state = (s == FSD_RREC) || (s == FSD_RRES);
  endfunction

  // ------------------------------------------------------------
  // Fault signalling
  // ------------------------------------------------------------
  // Condition code is one-hot; mask selects accepted codes
  assign cond_met = |(fault_if_cond_in &
                      arith_ctl_in[`FSD_AC_CC_LSB +: 3]); // RL3
  always_comb begin
    trig = 1'b0;
    trig_info = fault_info_in;
    if (fault_in) begin
      trig = 1'b1;
    end else if (fault_if_in && cond_met) begin
      trig = 1'b1; // RL3
      trig_info = '0;
      trig_info.ftype = `FSD_TYPE_CONSTRAINT;
      trig_info.subtype = `FSD_SUB_RANGE;
      trig_info.fault_ip = cur_ip_in;
    end else if (trace_event_in && proc_ctl_in[`FSD_PC_TRACE_EN_BIT] &&
                 |(trace_mode_in & trace_sub_in)) begin
      trig = 1'b1; // RL2
      trig_info = '0;
      trig_info.ftype = `FSD_TYPE_TRACE;
      // Subtype carries the trace modes that fired
      trig_info.subtype = trace_mode_in & trace_sub_in;
      trig_info.fault_ip = cur_ip_in;
    end
  end

  // ------------------------------------------------------------
  // Memory write data sequencing
  // ------------------------------------------------------------
  // Record layout: ctl words, fault data, type word, fault IP
  always_comb begin
    next_addr = word_addr(base, idx); // RL11
    next_wdata = 32'h0;
    case (state)
      FSD_WREC: begin
        case (idx)
          4'h0: next_wdata = saved_pc; // RL7
          4'h1: next_wdata = saved_ac; // RL7
          4'h2: next_wdata = rec.data0; // RL8
          4'h3: next_wdata = rec.data1; // RL8
          4'h4: next_wdata = rec.data2; // RL8
          4'h5: next_wdata = {rec.flags, 8'h0, rec.subtype,
                              rec.ftype}; // RL4 RL5
          default: next_wdata = rec.fault_ip; // RL6
        endcase
      end
      FSD_WRES: begin
        next_addr = res_addr(base, idx); // RL10
        next_wdata = resume_word_in;
      end
      FSD_WRIP: begin
        next_addr = old_fp + `FSD_RIP_OFFSET; // RL9
        next_wdata = ret_ip;
      end
      // Saved process controls are word 0 of the record
      FSD_RREC: next_addr = base; // RL20
      FSD_RRES: next_addr = res_addr(base, idx); // RL21
      default: next_addr = 32'h0;
    endcase
  end

  // Request stays up until the acknowledge edge
  assign mem_valid_out = mem_state(state);
  assign mem_req_out = '{write: !read_state(state),
                         addr: next_addr, wdata: next_wdata};
  assign busy_out = (state != FSD_IDLE);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // One fault at a time; new faults while busy are left to the core
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= FSD_IDLE;
      rec <= '0;
      saved_pc <= 32'h0;
      saved_ac <= 32'h0;
      base <= 32'h0;
      ret_ip <= 32'h0;
      old_fp <= 32'h0;
      idx <= 4'h0;
      supv_call <= 1'b0;
      from_user <= 1'b0;
      etype <= 2'h0;
    end else begin
      case (state)
        FSD_IDLE: begin
          idx <= 4'h0;
          if (trig) begin
            rec <= trig_info;
            saved_pc <= proc_ctl_in; // RL7
            saved_ac <= arith_ctl_in; // RL7
            // Records land on whichever stack the core is using
            base <= sp_in; // RL11 RL17 RL18
            old_fp <= fp_in;
            ret_ip <= next_ip_in; // RL9
            etype <= entry_word_in[1:0];
            supv_call <= (entry_word_in[1:0] == `FSD_ENTRY_SYSTEM) &&
                         pt_supv_in;
            from_user <= !proc_ctl_in[`FSD_PC_SUPV_BIT];
            // Later write of the resume bit wins over the plain copy
            if (trig_info.suspended) begin
              saved_pc[`FSD_PC_RESUME_BIT] <= 1'b1; // RL13
            end
            state <= FSD_WREC; // RL12
          end
        end
        FSD_WREC: if (mem_ack_in) begin
          idx <= idx + 4'h1;
          if (last_word(idx, 4'(`FSD_REC_WORDS))) begin
            idx <= 4'h0;
            state <= rec.suspended ? FSD_WRES : FSD_WRIP; // RL13
          end
        end
        FSD_WRES: if (mem_ack_in) begin
          idx <= idx + 4'h1;
          if (last_word(idx, 4'(`FSD_RESUME_WORDS))) begin
            idx <= 4'h0;
            state <= FSD_WRIP; // RL10
          end
        end
        FSD_WRIP: if (mem_ack_in) state <= FSD_CALL;
        FSD_CALL: state <= FSD_RUN;
        // Local returns end here; supervisor returns reload first
        FSD_RUN: if (handler_ret_in) begin
          state <= supv_call ? FSD_RREC : FSD_IDLE; // RL15 RL20
        end
        // Handler edits to the controls never reach the saved copy
        FSD_RREC: if (mem_ack_in) begin
          saved_pc <= mem_rdata_in; // RL20 RL22
          idx <= 4'h0;
          state <= mem_rdata_in[`FSD_PC_RESUME_BIT] ? FSD_RRES : FSD_IDLE;
        end
        FSD_RRES: if (mem_ack_in) begin
          idx <= idx + 4'h1;
          if (last_word(idx, 4'(`FSD_RESUME_WORDS))) state <= FSD_IDLE; // RL21
        end
        default: state <= FSD_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Dispatch and return outputs
  // ------------------------------------------------------------
  // Handler frame opens above the records on the stack in use
  assign frame_base = base + `FSD_FRAME_OFFSET; // RL18

  // Registered so the core sees stable values with each pulse
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      handler_ip_out <= 32'h0;
      new_fp_out <= 32'h0;
      new_sp_out <= 32'h0;
      frame_status_out <= 3'h0;
      proc_ctl_out <= 32'h0;
      arith_ctl_out <= 32'h0;
      return_ip_out <= 32'h0;
      ctl_load_out <= 1'b0;
      dispatch_out <= 1'b0;
      resume_out <= 1'b0;
      resume_data_out <= 32'h0;
      resume_valid_out <= 1'b0;
    end else begin
      ctl_load_out <= 1'b0;
      dispatch_out <= 1'b0;
      resume_out <= 1'b0;
      resume_valid_out <= 1'b0;
      if (state == FSD_CALL) begin
        dispatch_out <= 1'b1;
        frame_status_out <= `FSD_FRAME_STATUS; // RL14
        handler_ip_out <= (etype == `FSD_ENTRY_LOCAL) ?
                          {entry_word_in[31:2], 2'h0} : // RL12
                          pt_handler_in; // RL16
        proc_ctl_out <= proc_ctl_in;
        if (supv_call) begin
          proc_ctl_out[`FSD_PC_SUPV_BIT] <= 1'b1; // RL17
          proc_ctl_out[`FSD_PC_TRACE_EN_BIT] <=
            pt_ctl_word_in[`FSD_PT_TRACE_BIT]; // RL19
          ctl_load_out <= 1'b1;
        end
        // Frame opens at the supervisor stack pointer for a supervisor call from user mode, else above the records just pushed
        if (supv_call && from_user) begin
          new_fp_out <= pt_sp_in; // RL17
          new_sp_out <= pt_sp_in + `FSD_FRAME_BYTES;
        end else begin
          new_fp_out <= frame_base; // RL18
          new_sp_out <= frame_base + `FSD_FRAME_BYTES;
        end
      end
      // Arithmetic controls come back on every kind of return
      if (state == FSD_RUN && handler_ret_in) begin
        arith_ctl_out <= saved_ac; // RL15
        proc_ctl_out <= proc_ctl_in;
        return_ip_out <= ret_ip; // RL15
        new_fp_out <= old_fp; // RL15
        new_sp_out <= base;
        if (!supv_call) begin
          ctl_load_out <= 1'b1;
          resume_out <= 1'b1;
        end
      end
      // Handler changes to the process controls are dropped here
      if (state == FSD_RREC && mem_ack_in) begin
        proc_ctl_out <= mem_rdata_in; // RL20 RL22
        ctl_load_out <= 1'b1;
        resume_out <= !mem_rdata_in[`FSD_PC_RESUME_BIT];
      end
      if (state == FSD_RRES && mem_ack_in) begin
        resume_data_out <= mem_rdata_in; // RL21
        resume_valid_out <= 1'b1;
        // Last resumption word releases the suspended instruction
        resume_out <= last_word(idx, 4'(`FSD_RESUME_WORDS)); // RL21
      end
    end
  end
endmodule // fsd_unit
`default_nettype wire

// ===== fsd_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fsd_unit_chk (
  input wire logic clk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire logic fault_in, // Implicit fault
  input wire logic fault_if_in, // Fault-if
  input wire logic [2:0] fault_if_cond_in, // Condition mask
  input wire logic trace_event_in, // Trace event
  input wire logic [31:0] proc_ctl_in, // Process controls
  input wire logic [31:0] arith_ctl_in, // Arithmetic controls
  input wire logic [31:0] sp_in, // Stack pointer
  input wire logic [31:0] next_ip_in, // Next IP
  input wire logic [31:0] entry_word_in, // Table entry
  input wire logic [31:0] pt_handler_in, // Table handler
  input wire logic pt_supv_in, // Supervisor entry
  input wire logic [31:0] pt_ctl_word_in, // Table control word
  input wire fsd_pkg::fsd_mem_req_s mem_req_out, // Memory request
  input wire logic mem_valid_out, // Request valid
  input wire logic busy_out, // Busy
  input wire logic dispatch_out, // Dispatch pulse
  input wire logic [2:0] frame_status_out, // Frame status
  input wire logic [31:0] handler_ip_out, // Handler IP
  input wire logic [31:0] proc_ctl_out, // Controls out
  input wire logic resume_out, // Resume pulse
  input wire logic [31:0] return_ip_out // Return IP
);
  import fsd_pkg::*;
  logic [31:0] saved_ip;
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  // Return point as seen when any fault input arrives while idle; the design has no port
  // that exposes it, so keep our own copy
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      saved_ip <= 32'h00000000;
    end else if (!busy_out && (fault_in || fault_if_in || trace_event_in)) begin
      saved_ip <= next_ip_in;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_taken;
    fault_in && !busy_out;
  endsequence
  sequence s_fif;
    fault_if_in && !busy_out && !fault_in;
  endsequence
  a_trace_gate: assert property (trace_event_in && !proc_ctl_in[0] && !busy_out && !fault_in && !fault_if_in |=> !mem_valid_out) else $error("trace fault while disabled");
  a_fif_take: assert property (s_fif ##0 ((fault_if_cond_in & arith_ctl_in[2:0]) != 3'h0) |=> mem_valid_out && mem_req_out.write && mem_req_out.addr == $past(sp_in)) else $error("fault-if not raised");
  a_fif_skip: assert property (s_fif ##0 ((fault_if_cond_in & arith_ctl_in[2:0]) == 3'h0 && !trace_event_in) |=> !mem_valid_out) else $error("fault-if raised wrongly");
  a_ctl_capture: assert property (s_taken |=> (mem_req_out.wdata & ~32'h00000200) == ($past(proc_ctl_in) & ~32'h00000200)) else $error("controls not captured");
  a_frame_status: assert property (dispatch_out |-> frame_status_out == 3'h1) else $error("bad frame status");
  a_local_target: assert property (dispatch_out && entry_word_in[1:0] == 2'h0 |-> handler_ip_out == {entry_word_in[31:2], 2'h0}) else $error("bad local handler");
  a_table_target: assert property (dispatch_out && entry_word_in[1:0] == 2'h2 |-> handler_ip_out == pt_handler_in) else $error("bad table handler");
  a_supv_trace: assert property (dispatch_out && entry_word_in[1:0] == 2'h2 && pt_supv_in |-> proc_ctl_out[0] == pt_ctl_word_in[1] && proc_ctl_out[1]) else $error("bad supervisor controls");
  a_return_ip: assert property (resume_out |-> return_ip_out == saved_ip) else $error("bad return point");
endmodule // fsd_unit_chk
bind fsd_unit fsd_unit_chk u_chk (.*);
`default_nettype wire

// ===== fsd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsd_mem_model (
  input wire logic clk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire fsd_pkg::fsd_mem_req_s req_in, // Request
  input wire logic valid_in, // Request valid
  input wire logic [3:0] delay_in, // Wait states
  output logic [31:0] rdata_out, // Read data
  output logic ack_out // Acknowledge
);
  import fsd_pkg::*;
  logic [31:0] mem [logic [31:0]];
  int wr_count;
  int wait_cnt;
  // Stacks and tables in one sparse store; read data toggles when idle so
  // a stale word is never mistaken for an answer
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_out <= 1'b0;
      rdata_out <= 32'h00000000;
      wait_cnt = 0;
      wr_count = 0;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (valid_in && !ack_out) begin
        if (wait_cnt < int'(delay_in)) begin
          wait_cnt = wait_cnt + 1;
        end else begin
          wait_cnt = 0;
          ack_out <= 1'b1;
          if (req_in.write) begin
            mem[req_in.addr] = req_in.wdata;
            wr_count = wr_count + 1;
          end else begin
            rdata_out <= mem.exists(req_in.addr) ? mem[req_in.addr] : 32'h0;
          end
        end
      end
    end
  end
endmodule // fsd_mem_model
`default_nettype wire

// ===== test_fault_signal_and_dispatch.sv
`timescale 1ns/1ps
`default_nettype none
module test_fault_signal_and_dispatch;
  import fsd_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, fault_in = 0, fault_if_in = 0;
  logic trace_event_in = 0, handler_ret_in = 0, pt_supv_in = 0;
  logic mem_ack_in, mem_valid_out, resume_valid_out, ctl_load_out;
  logic dispatch_out, resume_out, busy_out;
  logic [7:0] trace_mode_in, trace_sub_in;
  logic [2:0] fault_if_cond_in, frame_status_out;
  logic [3:0] delay;
  logic [31:0] cur_ip_in, next_ip_in, proc_ctl_in, arith_ctl_in, sp_in, fp_in;
  logic [31:0] entry_word_in, pt_handler_in, pt_sp_in, pt_ctl_word_in;
  logic [31:0] resume_word_in, mem_rdata_in, resume_data_out, handler_ip_out;
  logic [31:0] new_fp_out, new_sp_out, proc_ctl_out, arith_ctl_out;
  logic [31:0] return_ip_out;
  fsd_fault_s fault_info_in;
  fsd_stack_e stack_in;
  fsd_mem_req_s mem_req_out;
  int err_count = 0, check_count = 0, cyc = 0, base, nres;
  bit seen_ret;
  always #20 clk_in = ~clk_in;
  fsd_unit u_dut (.*);
  fsd_mem_model u_mem (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .req_in(mem_req_out), .valid_in(mem_valid_out), .delay_in(delay),
    .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task test_done;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Inputs always move 1 ns after the rising edge
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task pulse(input int k);
    fault_in = (k == 0);
    fault_if_in = (k == 1);
    trace_event_in = (k == 2);
    handler_ret_in = (k == 3);
    tick(1);
    {fault_in, fault_if_in, trace_event_in, handler_ret_in} = 4'h0;
  endtask
  // Bounded wait for dispatch (k=0) or resume (k=1); pulses seen mid-cycle
  task wait_for(input int k, output bit seen);
    seen = 0;
    nres = 0;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(negedge clk_in);
      if (resume_valid_out === 1'b1) nres++;
      seen = (k == 0) ? (dispatch_out === 1'b1) : (resume_out === 1'b1);
    end
  endtask
  task run(input int k, input bit hit, input logic [31:0] hip);
    bit seen;
    base = u_mem.wr_count;
    pulse(k);
    wait_for(0, seen);
    chk(32'(seen), 32'(hit));
    if (seen) chk(32'(frame_status_out), 32'h1);
    if (seen) chk(handler_ip_out, hip);
    if (!seen) chk(32'(u_mem.wr_count - base), 32'h0);
    tick(1);
  endtask
  task ret(input bit supv);
    bit seen;
    pulse(3);
    wait_for(1, seen);
    chk(32'(seen), 32'h1);
    chk(arith_ctl_out, 32'h00008002);
    chk(return_ip_out, 32'h00003004);
    if (supv) chk(proc_ctl_out, 32'h00000201);
    if (supv) chk(32'(nres), 32'hC);
    if (supv) chk(resume_data_out, 32'hC0DE0001);
    tick(1);
  endtask
  // Cut a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fault_info_in = '{8'h0A, 8'h03, 8'h5A, 32'h00003000, 32'h11111111,
      32'h22222222, 32'h33333333, 1'b0};
    {cur_ip_in, next_ip_in, proc_ctl_in} = {32'h3000, 32'h3004, 32'h1};
    arith_ctl_in = 32'h00008002;
    {sp_in, fp_in, entry_word_in} = {32'h4000, 32'h3F00, 32'h1000};
    {pt_handler_in, pt_sp_in, pt_ctl_word_in} = {32'h2000, 32'h8000, 32'h0};
    resume_word_in = 32'hC0DE0001;
    {trace_mode_in, trace_sub_in, fault_if_cond_in} = {8'h0C, 8'h04, 3'h0};
    stack_in = FSD_STK_LOCAL;
    delay = 4'h0;
    repeat (12) @(posedge clk_in);
    #1 sys_rst_in = 0;
    run(0, 1, 32'h1000);
    chk(u_mem.mem[sp_in], 32'h1);
    chk(u_mem.mem[sp_in + 4], 32'h00008002);
    chk(u_mem.mem[sp_in + 8], 32'h11111111);
    chk(u_mem.mem[sp_in + 20] & 32'h00FFFFFF, 32'h0000030A);
    chk(u_mem.mem[sp_in + 24], 32'h3000);
    chk(u_mem.mem[fp_in + 8], 32'h3004);
    chk(32'(u_mem.wr_count - base), 32'h9);
    ret(0);
    $display("test local call done");
    // Slow memory, suspended instruction, supervisor handler from user mode
    {entry_word_in, pt_supv_in, delay} = {32'h2, 1'b1, 4'h3};
    fault_info_in.suspended = 1'b1;
    run(0, 1, 32'h2000);
    chk(u_mem.mem[sp_in], 32'h00000201);
    chk(u_mem.mem[sp_in + 76], 32'hC0DE0001);
    chk(32'(u_mem.wr_count - base), 32'h15);
    chk(new_fp_out, 32'h8000);
    chk(new_sp_out, 32'h8040);
    chk(proc_ctl_out & 32'h3, 32'h2);
    proc_ctl_in = 32'h00000402; // Handler sets pending trace
    ret(1);
    $display("test supervisor call done");
    // Supervisor handler entered from supervisor mode, trace flag set
    {entry_word_in, pt_supv_in, delay} = {32'h2, 1'b1, 4'h0};
    {fault_info_in.suspended, proc_ctl_in} = {1'b0, 32'h2};
    pt_ctl_word_in = 32'h2;
    run(0, 1, 32'h2000);
    chk(u_mem.mem[sp_in], 32'h2);
    chk(new_fp_out, 32'h4060);
    chk(new_sp_out, 32'h40A0);
    chk(proc_ctl_out & 32'h3, 32'h3);
    pulse(3);
    wait_for(1, seen_ret);
    chk(32'(seen_ret), 32'h1);
    chk(proc_ctl_out, 32'h2);
    chk(return_ip_out, 32'h00003004);
    chk(32'(nres), 32'h0);
    tick(1);
    pt_ctl_word_in = 32'h0;
    $display("test supervisor from supervisor done");
    {entry_word_in, pt_supv_in, delay} = {32'h1000, 1'b0, 4'h0};
    fault_info_in.suspended = 1'b0;
    proc_ctl_in = 32'h1;
    for (int m = 0; m < 8; m++) begin
      fault_if_cond_in = 3'(m);
      run(1, (m & 2) != 0, 32'h1000);
      if ((m & 2) != 0) chk(u_mem.mem[sp_in + 20] & 32'hFFFFFF, 32'h105);
      if ((m & 2) != 0) ret(0);
    end
    $display("test fault-if done");
    run(2, 1, 32'h1000);
    chk(u_mem.mem[sp_in + 20] & 32'h00FFFFFF, 32'h00000401);
    ret(0);
    proc_ctl_in = 32'h0;
    run(2, 0, 32'h1000);
    {proc_ctl_in, trace_mode_in} = {32'h1, 8'h08};
    run(2, 0, 32'h1000);
    $display("test trace done");
    test_done;
  end
endmodule // test_fault_signal_and_dispatch
`default_nettype wire
